/* File: logic/serial_divider.sv */
// restoring divider, one quotient bit per clock
// assumes a non-zero divisor; start is ignored while busy
`timescale 1ns/10ps
module serial_divider #(
  parameter int NW = 42,
  parameter int DW = 19
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          start,
  input  wire logic [NW-1:0] num,
  input  wire logic [DW-1:0] den,
  output logic               done,
  output logic [NW-1:0]      quo
);
  typedef struct packed {
    logic [NW-1:0] q;
    logic [DW:0]   r;
    logic [DW-1:0] d;
    logic [5:0]    n;
    logic          busy;
    logic          done;
  } div_t;

  div_t s, next_s;
  logic [DW:0] trial;

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    trial = '0;
    if (!s.busy) begin
      if (start) begin
        next_s.q = num;
        next_s.r = '0;
        next_s.d = den;
        next_s.n = 6'(NW);
        next_s.busy = 1'b1;
      end
    end else begin
      trial = {s.r[DW-1:0], s.q[NW-1]};
      next_s.q = {s.q[NW-2:0], 1'b0};
      if (trial >= {1'b0, s.d}) begin
        next_s.r = trial - {1'b0, s.d};
        next_s.q[0] = 1'b1;
      end else begin
        next_s.r = trial;
      end
      next_s.n = s.n - 6'h01;
      if (s.n == 6'h01) begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign done = s.done;
  assign quo  = s.q;
endmodule

/* File: logic/stuck_timer.sv */
// counts cycles a frame waits at the head; flags once the limit is reached
// assumes clr and inc come from logic on aclk
`timescale 1ns/10ps
module stuck_timer #(
  parameter int LIMIT = 10000
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic clr,
  input  wire logic inc,
  output logic      expired
);
  typedef struct packed {
    logic [31:0] cnt;
  } tmr_t;

  tmr_t s, next_s;

  always_comb begin
    next_s = s;
    if (clr) begin
      next_s.cnt = '0;
    end else if (inc && s.cnt < 32'(LIMIT)) begin
      next_s.cnt = s.cnt + 32'h00000001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign expired = (s.cnt >= 32'(LIMIT));
endmodule

/* File: logic/tx_gap_rate_limiter_aging.sv */
// transmit side of one switch port: backpressure, frame aging, gap rate limiting
// assumes a byte stream from the queue system and a byte-wide port mac
// Operation
// - collide enable turns flow control into backpressure
// - pass flow control state to port collide or pause request
// - per-port enable for aging stuck frames
// - discard stuck frames and era-old frames
// - each aged frame increments readable saturating tally
// - three rate modes enabled independently
// - added gap is largest enabled extension
// - overhead plus payload summed when sum enabled and frame spacing mode off
// - preamble selection counts preamble as payload
// - header count subtracted, one shared value
// - payload adjustments skip overhead mode
// - overhead and payload extensions scaled by two to exponent
// - overhead mode raises minimum gap to value
// - payload increase is 2^S*256/R*L
// - gap is twelve bytes plus increase
// - fractional remainder carried to next gap
// - spacing counter loaded then decremented per payload byte
// - spacing remainder above twelve extends gap
`timescale 1ns/10ps
module tx_gap_rate_limiter_aging #(
  parameter int AGE_LIMIT = gap_limiter_pkg::AGE_CYCLES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        fc_request,
  input  wire logic        pause_hold,
  input  wire logic        in_valid,
  output logic             in_ready,
  input  wire logic [7:0]  in_data,
  input  wire logic        in_sof,
  input  wire logic        in_eof,
  input  wire logic        in_era_old,
  output logic             out_valid,
  input  wire logic        out_ready,
  output logic [7:0]       out_data,
  output logic             out_sof,
  output logic             out_eof,
  output logic             hdx_collide,
  output logic             fdx_pause_req
);
  localparam int GW = gap_limiter_pkg::GW;

  typedef struct packed {
    gap_limiter_pkg::tx_state_t st;
    logic          half_duplex_collide_enable;
    logic          age_en;
    logic          overhead_mode_enable;
    logic          payload_rate_mode_enable;
    logic          frame_spacing_mode_enable;
    logic          gap_sum_enable;
    logic          preamble_in_payload_sel;
    logic          hdr_sel;
    logic [3:0]    gap_scale_exponent;
    logic [7:0]    overhead_gap_bytes;
    logic [18:0]   stretch_ratio_value;
    logic [15:0]   fr_start;
    logic [7:0]    header_byte_count;
    logic [31:0]   aged_frame_tally;
    logic [GW-1:0] last_gap;
    logic [15:0]   byte_idx;
    logic [15:0]   plen;
    logic [15:0]   fr_cnt;
    logic [7:0]    frac;
    logic [GW-1:0] gap;
    logic          pend;
    logic          div_go;
    logic          div_start;
    logic          in_ready;
    logic          out_valid;
    logic [7:0]    out_data;
    logic          out_sof;
    logic          out_eof;
    logic          collide;
    logic          pause_req;
    logic          aw_got;
    logic [7:0]    aw_addr;
    logic          w_got;
    logic [31:0]   w_data;
    logic [3:0]    w_strb;
    logic          awready;
    logic          wready;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          arready;
    logic          rvalid;
    logic [31:0]   rdata;
    logic [1:0]    rresp;
  } state_t;

  state_t s, next_s;

  logic                div_done;
  logic [41:0]         div_quo;
  logic                age_expired;
  logic                head_wait;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [GW-1:0] gmax(input logic [GW-1:0] a,
                                         input logic [GW-1:0] b);
    return (a > b) ? a : b;
  endfunction

  // ****************************************
  // sub-blocks
  // ****************************************
  // a frame that cannot leave because transmission is paused
  assign head_wait = (s.st == gap_limiter_pkg::ST_IDLE) && in_valid && in_sof && pause_hold;

  stuck_timer #(
    .LIMIT (AGE_LIMIT)
  ) u_stuck (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clr     (!head_wait),
    .inc     (head_wait),
    .expired (age_expired)
  );

  serial_divider #(
    .NW (gap_limiter_pkg::NUM_W),
    .DW (gap_limiter_pkg::DEN_W)
  ) u_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (s.div_start),
    .num     ({26'h0000000, s.plen} << (5'(s.gap_scale_exponent) + 5'h10)),
    .den     (s.stretch_ratio_value),
    .done    (div_done),
    .quo     (div_quo)
  );

  // ****************************************
  // next state
  // ****************************************
  logic          take;
  logic          pay_byte;
  logic [GW-1:0] oh_ext;
  logic [GW-1:0] pr_ext;
  logic [GW-1:0] fr_ext;
  logic [GW-1:0] ext;
  logic [42:0]   pr_tot;
  logic [31:0]   wv;

  always_comb begin
    next_s = s;
    take = in_valid && s.in_ready;
    pay_byte = 1'b0;
    oh_ext = '0;
    pr_ext = '0;
    fr_ext = '0;
    ext = '0;
    pr_tot = '0;
    wv = '0;
    next_s.div_start = 1'b0;

    // flow control towards the port module
    next_s.collide   = fc_request && s.half_duplex_collide_enable;
    next_s.pause_req = fc_request && !s.half_duplex_collide_enable;

    if (s.out_valid && out_ready) begin
      next_s.out_valid = 1'b0;
    end

    unique case (s.st)
      gap_limiter_pkg::ST_IDLE: begin
        if (in_valid && in_sof) begin
          if (s.age_en && (in_era_old || age_expired)) begin
            next_s.st = gap_limiter_pkg::ST_DROP;
            if (s.aged_frame_tally != 32'hFFFFFFFF) begin
              next_s.aged_frame_tally = s.aged_frame_tally + 32'h00000001;
            end
          end else if (!pause_hold) begin
            next_s.st = gap_limiter_pkg::ST_SEND;
            next_s.byte_idx = '0;
            next_s.plen = s.preamble_in_payload_sel ? gap_limiter_pkg::PREAMBLE_BYTES : '0;
            if (s.preamble_in_payload_sel) begin
              next_s.fr_cnt = (s.fr_start > gap_limiter_pkg::PREAMBLE_BYTES) ?
                              s.fr_start - gap_limiter_pkg::PREAMBLE_BYTES : '0;
            end else begin
              next_s.fr_cnt = s.fr_start;
            end
          end
        end
      end
      gap_limiter_pkg::ST_SEND: begin
        if (take) begin
          next_s.out_valid = 1'b1;
          next_s.out_data  = in_data;
          next_s.out_sof   = in_sof;
          next_s.out_eof   = in_eof;
          // header bytes are not payload
          pay_byte = !s.hdr_sel || (s.byte_idx >= {8'h00, s.header_byte_count});
          if (s.byte_idx != 16'hFFFF) begin
            next_s.byte_idx = s.byte_idx + 16'h0001;
          end
          if (pay_byte && s.plen != 16'hFFFF) begin
            next_s.plen = s.plen + 16'h0001;
          end
          if (pay_byte && s.fr_cnt != 16'h0000) begin
            next_s.fr_cnt = s.fr_cnt - 16'h0001;
          end
          if (in_eof) begin
            next_s.st = gap_limiter_pkg::ST_GAP;
            next_s.gap = gap_limiter_pkg::GAP_STD;
            next_s.pend = 1'b1;
            next_s.div_go = s.payload_rate_mode_enable;
          end
        end
      end
      gap_limiter_pkg::ST_DROP: begin
        if (take && in_eof) begin
          next_s.st = gap_limiter_pkg::ST_IDLE;
        end
      end
      gap_limiter_pkg::ST_GAP: begin
        if (s.div_go) begin
          next_s.div_start = 1'b1;
          next_s.div_go = 1'b0;
        end
        // gap time starts once the last byte has left
        if (!s.out_valid && s.gap != '0) begin
          next_s.gap = s.gap - 28'h0000001;
        end
        if (s.pend && !s.div_go && !s.div_start && (div_done || !s.payload_rate_mode_enable)) begin
          next_s.pend = 1'b0;
          if (s.overhead_mode_enable && s.overhead_gap_bytes > 8'h0C) begin
            oh_ext = GW'(s.overhead_gap_bytes - 8'h0C) << s.gap_scale_exponent;
          end
          if (s.payload_rate_mode_enable) begin
            pr_tot = {1'b0, div_quo} + {35'h000000000, s.frac};
            pr_ext = GW'(pr_tot >> gap_limiter_pkg::FRAC_BITS);
            next_s.frac = pr_tot[7:0];
          end
          if (s.frame_spacing_mode_enable && s.fr_cnt > 16'h000C) begin
            fr_ext = {12'h000, s.fr_cnt};
          end
          if (s.gap_sum_enable && s.overhead_mode_enable && s.payload_rate_mode_enable &&
              !s.frame_spacing_mode_enable) begin
            ext = oh_ext + pr_ext;
          end else begin
            ext = gmax(gmax(oh_ext, pr_ext), fr_ext);
          end
          next_s.gap = next_s.gap + ext;
          next_s.last_gap = gap_limiter_pkg::GAP_STD + ext;
        end
        if (!s.pend && !s.out_valid && s.gap == '0) begin
          next_s.st = gap_limiter_pkg::ST_IDLE;
        end
      end
    endcase

    // one byte in flight: accept only into an empty output stage
    next_s.in_ready = ((next_s.st == gap_limiter_pkg::ST_SEND) && !next_s.out_valid) ||
                      ((next_s.st == gap_limiter_pkg::ST_DROP) && !(take && in_eof));

    // ****************************************
    // register write
    // ****************************************
    if (awvalid && s.awready) begin
      next_s.aw_got = 1'b1;
      next_s.aw_addr = awaddr;
      next_s.awready = 1'b0;
    end
    if (wvalid && s.wready) begin
      next_s.w_got = 1'b1;
      next_s.w_data = wdata;
      next_s.w_strb = wstrb;
      next_s.wready = 1'b0;
    end
    if (s.aw_got && s.w_got && !s.bvalid) begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = gap_limiter_pkg::RESP_OKAY;
      unique case (s.aw_addr)
        gap_limiter_pkg::OFF_CTRL: begin
          wv = merge({20'h00000, s.gap_scale_exponent, s.hdr_sel,
                      s.preamble_in_payload_sel, s.gap_sum_enable,
                      s.frame_spacing_mode_enable, s.payload_rate_mode_enable,
                      s.overhead_mode_enable, s.age_en,
                      s.half_duplex_collide_enable}, s.w_data, s.w_strb);
          next_s.half_duplex_collide_enable = wv[gap_limiter_pkg::CTRL_HDX];
          next_s.age_en = wv[gap_limiter_pkg::CTRL_AGE];
          next_s.overhead_mode_enable = wv[gap_limiter_pkg::CTRL_OH];
          next_s.payload_rate_mode_enable = wv[gap_limiter_pkg::CTRL_PR];
          next_s.frame_spacing_mode_enable = wv[gap_limiter_pkg::CTRL_FR];
          next_s.gap_sum_enable = wv[gap_limiter_pkg::CTRL_SUM];
          next_s.preamble_in_payload_sel = wv[gap_limiter_pkg::CTRL_PRE];
          next_s.hdr_sel = wv[gap_limiter_pkg::CTRL_HDR];
          next_s.gap_scale_exponent = wv[gap_limiter_pkg::CTRL_SCALE_L +: 4];
        end
        gap_limiter_pkg::OFF_OVERHEAD: begin
          wv = merge({24'h000000, s.overhead_gap_bytes}, s.w_data, s.w_strb);
          next_s.overhead_gap_bytes = wv[7:0];
        end
        gap_limiter_pkg::OFF_STRETCH: begin
          wv = merge({13'h0000, s.stretch_ratio_value}, s.w_data, s.w_strb);
          next_s.stretch_ratio_value = wv[18:0];
        end
        gap_limiter_pkg::OFF_FRSTART: begin
          wv = merge({16'h0000, s.fr_start}, s.w_data, s.w_strb);
          next_s.fr_start = wv[15:0];
        end
        gap_limiter_pkg::OFF_HEADER: begin
          wv = merge({24'h000000, s.header_byte_count}, s.w_data, s.w_strb);
          next_s.header_byte_count = wv[7:0];
        end
        gap_limiter_pkg::OFF_AGED, gap_limiter_pkg::OFF_LASTGAP: begin
          next_s.bresp = gap_limiter_pkg::RESP_OKAY;
        end
        default: begin
          next_s.bresp = gap_limiter_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
      next_s.awready = 1'b1;
      next_s.wready = 1'b1;
    end

    // ****************************************
    // register read
    // ****************************************
    if (arvalid && s.arready) begin
      next_s.arready = 1'b0;
      next_s.rvalid = 1'b1;
      next_s.rresp = gap_limiter_pkg::RESP_OKAY;
      unique case (araddr)
        gap_limiter_pkg::OFF_CTRL: begin
          next_s.rdata = {20'h00000, s.gap_scale_exponent, s.hdr_sel,
                          s.preamble_in_payload_sel, s.gap_sum_enable,
                          s.frame_spacing_mode_enable, s.payload_rate_mode_enable,
                          s.overhead_mode_enable, s.age_en,
                          s.half_duplex_collide_enable};
        end
        gap_limiter_pkg::OFF_OVERHEAD: next_s.rdata = {24'h000000, s.overhead_gap_bytes};
        gap_limiter_pkg::OFF_STRETCH:  next_s.rdata = {13'h0000, s.stretch_ratio_value};
        gap_limiter_pkg::OFF_FRSTART:  next_s.rdata = {16'h0000, s.fr_start};
        gap_limiter_pkg::OFF_HEADER:   next_s.rdata = {24'h000000, s.header_byte_count};
        gap_limiter_pkg::OFF_AGED:     next_s.rdata = s.aged_frame_tally;
        gap_limiter_pkg::OFF_LASTGAP:  next_s.rdata = {4'h0, s.last_gap};
        default: begin
          next_s.rdata = '0;
          next_s.rresp = gap_limiter_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
      next_s.arready = 1'b1;
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.st <= gap_limiter_pkg::ST_IDLE;
      s.overhead_gap_bytes <= gap_limiter_pkg::RST_OVERHEAD;
      s.stretch_ratio_value <= gap_limiter_pkg::RST_STRETCH;
      s.fr_start <= gap_limiter_pkg::RST_FRSTART;
      s.header_byte_count <= gap_limiter_pkg::RST_HEADER;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign awready       = s.awready;
  assign wready        = s.wready;
  assign bvalid        = s.bvalid;
  assign bresp         = s.bresp;
  assign arready       = s.arready;
  assign rvalid        = s.rvalid;
  assign rdata         = s.rdata;
  assign rresp         = s.rresp;
  assign in_ready      = s.in_ready;
  assign out_valid     = s.out_valid;
  assign out_data      = s.out_data;
  assign out_sof       = s.out_sof;
  assign out_eof       = s.out_eof;
  assign hdx_collide   = s.collide;
  assign fdx_pause_req = s.pause_req;
endmodule

/* File: pkg/gap_limiter_pkg.sv */
// constants, types and register map of the transmit gap limiter
// assumes a 100 MHz aclk and one byte per link byte time
package gap_limiter_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_OVERHEAD = 8'h04;
  localparam logic [7:0] OFF_STRETCH  = 8'h08;
  localparam logic [7:0] OFF_FRSTART  = 8'h0C;
  localparam logic [7:0] OFF_HEADER   = 8'h10;
  localparam logic [7:0] OFF_AGED     = 8'h14;
  localparam logic [7:0] OFF_LASTGAP  = 8'h18;

  // ctrl field positions
  localparam int CTRL_HDX     = 0;
  localparam int CTRL_AGE     = 1;
  localparam int CTRL_OH      = 2;
  localparam int CTRL_PR      = 3;
  localparam int CTRL_FR      = 4;
  localparam int CTRL_SUM     = 5;
  localparam int CTRL_PRE     = 6;
  localparam int CTRL_HDR     = 7;
  localparam int CTRL_SCALE_L = 8;

  // reset values
  localparam logic [7:0]  RST_OVERHEAD = 8'h0C;
  localparam logic [18:0] RST_STRETCH  = 19'h00480;
  localparam logic [15:0] RST_FRSTART  = 16'h0000;
  localparam logic [7:0]  RST_HEADER   = 8'h00;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // gap arithmetic
  // ****************************************
  localparam int GW = 28;
  localparam logic [GW-1:0] GAP_STD = 28'h000000C;
  localparam logic [15:0] PREAMBLE_BYTES = 16'h0008;
  localparam int FRAC_BITS = 8;
  localparam int NUM_W = 42;
  localparam int DEN_W = 19;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int AGE_TIME_NS   = 100000;
  localparam int AGE_CYCLES    = AGE_TIME_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SEND = 2'h1,
    ST_DROP = 2'h2,
    ST_GAP  = 2'h3
  } tx_state_t;

endpackage

/* File: tb/queue_mac_model.sv */
// queue system source and port mac sink
// assumes the bench calls send from one process at a time
`timescale 1ns/10ps
module queue_mac_model (
  input  wire logic aclk,
  input  wire logic in_ready,
  output logic       in_valid = 1'b0,
  output logic [7:0] in_data = 8'h00,
  output logic       in_sof = 1'b0,
  output logic       in_eof = 1'b0,
  output logic       in_era_old = 1'b0,
  output logic       out_ready = 1'b0
);
  // ****
  // source and sink
  // ****
  int seed = 42;
  // random stalls so held output bytes get exercised
  always @(posedge aclk) out_ready <= 1'($random(seed));
  task automatic send(input logic [7:0] b, input int n, input logic era);
    int   i;
    logic h;
    i = 0;
    @(posedge aclk);
    while (i < n) begin
      in_valid   <= 1'b1;
      in_data    <= b + 8'(i);
      in_sof     <= (i == 0);
      in_eof     <= (i == n - 1);
      in_era_old <= era && (i == 0);
      @(negedge aclk);
      h = in_ready;
      @(posedge aclk);
      if (h) i++;
    end
    in_valid <= 1'b0;
    // released lines show no stale byte
    in_data  <= ~in_data;
  endtask
endmodule

/* File: tb/tb.sv */
// self-checking bench for the transmit gap limiter
// assumes the checker binds itself to the design
`timescale 1ns/10ps
module tb;
  // ****
  // signals and scoreboard
  // ****
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hF;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        fc_request = 1'b0, pause_hold = 1'b0;
  wire  [31:0] rdata;
  wire  [7:0]  in_data, out_data;
  wire  [1:0]  bresp, rresp;
  wire         awready, wready, bvalid, arready, rvalid, in_ready, out_valid, out_sof, out_eof;
  wire         in_valid, in_sof, in_eof, in_era_old, out_ready, hdx_collide, fdx_pause_req;
  logic [33:0] axq[$];
  logic [9:0]  stq[$];
  int          mismatches = 0, checked = 0, cycles = 0, seed = 42;
  tx_gap_rate_limiter_aging #(.AGE_LIMIT(20)) tx_gap_rate_limiter_aging_inst (.*);
  queue_mac_model queue_mac_model_inst (.*);
  always #5 aclk = ~aclk;
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge aclk) begin
    if (bvalid && bready) chk({bresp, 32'h0}, axq.pop_front());
    if (rvalid && rready) chk({rresp, rdata}, axq.pop_front());
    if (out_valid && out_ready) chk({24'h0, out_sof, out_eof, out_data}, {24'h0, stq.pop_front()});
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      give_verdict();
    end
  end
  // ****
  // bus and frame tasks
  // ****
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    logic ta, tw;
    axq.push_back({r, 32'h0});
    ta = 1'b0;
    tw = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge aclk);
      ta = ta | awready;
      tw = tw | wready;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    do @(negedge aclk); while (!bvalid);
    @(posedge aclk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    axq.push_back({r, d});
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    @(posedge aclk);
    rready <= 1'b0;
  endtask
  // g is the expected total gap; zero marks a frame that must be aged out
  task automatic run(input logic [11:0] c, input int n, input logic era, input logic [31:0] g);
    logic [7:0] b;
    b = 8'($random(seed));
    wr(gap_limiter_pkg::OFF_CTRL, {20'h0, c});
    for (int i = 0; i < n; i++) begin
      if (g != 0) stq.push_back({i == 0, i == n - 1, b + 8'(i)});
    end
    queue_mac_model_inst.send(b, n, era);
    // longest gap and divider latency fit
    repeat (200) @(posedge aclk);
    if (g != 0) rd(gap_limiter_pkg::OFF_LASTGAP, g);
    $display("test ctrl %h len %0d done", c, n);
  endtask
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(gap_limiter_pkg::OFF_OVERHEAD, 32'h0C);
    rd(gap_limiter_pkg::OFF_STRETCH, 32'h480);
    rd(gap_limiter_pkg::OFF_FRSTART, 32'h0);
    rd(gap_limiter_pkg::OFF_HEADER, 32'h0);
    rd(8'h40, 32'h0, gap_limiter_pkg::RESP_SLVERR);
    wr(8'h40, 32'h5A, gap_limiter_pkg::RESP_SLVERR);
    wr(gap_limiter_pkg::OFF_AGED, 32'h5);
    rd(gap_limiter_pkg::OFF_AGED, 32'h0);
    wr(gap_limiter_pkg::OFF_OVERHEAD, 32'h14);
    wr(gap_limiter_pkg::OFF_STRETCH, 32'h480);
    wstrb <= 4'h1;
    wr(gap_limiter_pkg::OFF_FRSTART, 32'h0000_5528);
    wstrb <= 4'hF;
    wr(gap_limiter_pkg::OFF_HEADER, 32'h4);
    run(12'h000, 6, 1'b0, 12);
    run(12'h004, 6, 1'b0, 20);
    run(12'h104, 6, 1'b0, 28);
    run(12'h044, 6, 1'b0, 20);
    run(12'h010, 10, 1'b0, 42);
    run(12'h050, 10, 1'b0, 34);
    run(12'h090, 10, 1'b0, 46);
    run(12'h014, 10, 1'b0, 42);
    run(12'h008, 9, 1'b0, 14);
    run(12'h048, 1, 1'b0, 14);
    run(12'h02C, 9, 1'b0, 22);
    run(12'h00C, 9, 1'b0, 20);
    run(12'h008, 7, 1'b0, 13);
    run(12'h008, 7, 1'b0, 14);
    run(12'h002, 5, 1'b1, 0);
    @(posedge aclk) pause_hold <= 1'b1;
    run(12'h002, 5, 1'b0, 0);
    @(posedge aclk) pause_hold <= 1'b0;
    rd(gap_limiter_pkg::OFF_AGED, 32'h2);
    run(12'h000, 5, 1'b1, 12);
    for (int i = 0; i < 8; i++) stq.push_back({i % 4 == 0, i % 4 == 3, 8'(i % 4)});
    repeat (2) queue_mac_model_inst.send(8'h00, 4, 1'b0);
    $display("test back to back done");
    for (int k = 0; k < 2; k++) begin
      wr(gap_limiter_pkg::OFF_CTRL, 32'(k == 0));
      @(posedge aclk) fc_request <= 1'b1;
      repeat (3) @(posedge aclk);
      @(negedge aclk) chk({32'h0, hdx_collide, fdx_pause_req}, {32'h0, k == 0, k == 1});
      @(posedge aclk) fc_request <= 1'b0;
    end
    repeat (4) @(posedge aclk);
    give_verdict();
  end
endmodule

/* File: tb/tx_gap_asserts.sv */
// port checker for the transmit gap limiter
// assumes ctrl is written with address and data taken on one edge
`timescale 1ns/10ps
module tx_gap_asserts (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  awaddr,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic [31:0] wdata,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        fc_request,
  input wire logic        in_valid,
  input wire logic        in_ready,
  input wire logic [7:0]  in_data,
  input wire logic        in_sof,
  input wire logic        in_era_old,
  input wire logic        out_valid,
  input wire logic        out_ready,
  input wire logic [7:0]  out_data,
  input wire logic        out_sof,
  input wire logic        out_eof,
  input wire logic        hdx_collide,
  input wire logic        fdx_pause_req
);
  // ****
  // ctrl shadow and properties
  // ****
  logic [11:0] ctrl;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= 12'h000;
    end else if (awvalid && awready && wvalid && wready
                 && awaddr == gap_limiter_pkg::OFF_CTRL) begin
      ctrl <= wdata[11:0];
    end
  end
  default clocking dc @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_hdx_follow: assert property ($past(aresetn) |->
    hdx_collide == $past(fc_request && ctrl[0])) else $error("collide level wrong");
  a_pause_follow: assert property ($past(aresetn) |->
    fdx_pause_req == $past(fc_request && !ctrl[0])) else $error("pause level wrong");
  a_hdx_excl: assert property (!(hdx_collide && fdx_pause_req))
    else $error("collide and pause together");
  a_era_drop: assert property (ctrl[1] && in_valid && in_ready && in_sof && in_era_old
    |=> !out_valid [*3]) else $error("aged frame reached mac");
  a_byte_pass: assert property (!ctrl[1] && in_valid && in_ready |=> out_valid
    && out_data == $past(in_data) && out_sof == $past(in_sof)) else $error("byte lost");
  a_gap_floor: assert property (out_valid && out_ready && out_eof
    |=> !in_ready [*8] ##1 !in_ready [*4]) else $error("gap below twelve");
  a_write_refuse: assert property (awvalid && awready && wvalid && wready
    |=> !awready && !wready ##1 bvalid) else $error("write answer late");
  a_read_answer: assert property (arvalid && arready |=> !arready && rvalid)
    else $error("read answer late");
  a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("output byte not held");
endmodule
bind tx_gap_rate_limiter_aging tx_gap_asserts tx_gap_asserts_inst (.*);
